// ===== rtl/xlat_win_pkg.sv
// Purpose: shared constants for the upstream translation window registers
// Assumes: 32-bit register words on an 8-bit byte address
// Notes:   one name for every offset, field position and reset value
// What this block does
// - window 0 keeps a writable translated base in address bits 31:12 for upstream memory hits.
// - window 1 keeps a writable translated base in bits 31:6, bits 5:0 reading as zero.
// - how many base bits each window really uses is set by its own setup register.
// - setup bit 0, the space type, is read-only zero (memory) in both windows.
// - setup bits 2:1 give the address type, 00 for 32-bit and 01 for 64-bit, reset 00.
// - a size-mask bit at 1 makes the matching base bit writable, at 0 read-only.
// - window 0 enable bit 31 stays 1 even when zero is written or loaded.
// - window 1 enable bit 31 turns the window on, resetting to 0 so it starts off.
package xlat_win_pkg;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0]  OFF_W0_BASE   = 8'he0;
	localparam logic [7:0]  OFF_W0_SETUP  = 8'he4;
	localparam logic [7:0]  OFF_W1_BASE   = 8'he8;
	localparam logic [7:0]  OFF_W1_SETUP  = 8'hec;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int          TYPE_BIT      = 0;
	localparam int          ATYPE_LSB     = 1;
	localparam int          ATYPE_MSB     = 2;
	localparam int          PREF_BIT      = 3;
	localparam int          SIZE_MSB      = 30;
	localparam int          EN_BIT        = 31;
	localparam int          W0_LSB        = 12;
	localparam int          W1_LSB        = 6;

	// --------------------------------------------------------------
	// reset values and codes
	// --------------------------------------------------------------
	localparam logic [1:0]  ATYPE_32      = 2'h0;
	localparam logic [1:0]  ATYPE_64      = 2'h1;
	localparam logic [1:0]  ATYPE_RESET   = 2'h0;
	localparam logic        TYPE_MEMORY   = 1'b0;
	localparam logic        PREF_RESET    = 1'b0;
	localparam logic        W0_EN_RESET   = 1'b1;
	localparam logic        W1_EN_RESET   = 1'b0;
	localparam logic [31:0] BASE_RESET    = 32'h0;
	localparam logic [31:0] SIZE_RESET    = 32'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ===== rtl/axil_capture.sv
// Purpose: holds one AXI4-Lite write channel item until the write runs
// Assumes: the consumer pulses i_consume only while o_full is high
// Notes:   ready is a flop, so a taken item stalls the channel one edge
`timescale 1ns/1ns
`default_nettype none
module axil_capture #(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_payload,
	input  wire logic         i_consume,
	output logic              o_full,
	output logic [W-1:0]      o_payload
);
	logic full_d;

	assign full_d = (o_full & ~i_consume) | (i_valid & o_ready);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_full  <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			o_full  <= full_d;
			o_ready <= ~full_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_payload <= '0;
		end else if (i_valid & o_ready) begin
			o_payload <= i_payload;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/xlat_window.sv
// Purpose: one translation window, base and setup with its address merge
// Assumes: LSB between 4 and 30
// Notes:   bit 31 of the base is always writable and always translated
`timescale 1ns/1ns
`default_nettype none
module xlat_window
	import xlat_win_pkg::*;
#(
	parameter int   LSB       = W0_LSB,
	parameter logic ALWAYS_ON = 1'b1,
	parameter logic EN_RESET  = W0_EN_RESET
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_wr_base,
	input  wire logic [31:0] i_wr_data,
	input  wire logic [3:0]  i_wr_strb,
	input  wire logic        i_load,
	input  wire logic [31:0] i_load_data,
	input  wire logic [31:0] i_addr,
	output logic [31:0]      o_base,
	output logic [31:0]      o_setup,
	output logic [31:0]      o_xlat_addr,
	output logic             o_enabled
);
	logic [31:LSB]       base_q;
	logic [SIZE_MSB:LSB] size_q;
	logic [1:0]          atype_q;
	logic                pref_q;
	logic                en_q;
	logic [31:LSB]       wmask;
	logic [31:0]         lanes;
	logic [31:LSB]       bmask;

	assign wmask = {1'b1, size_q};
	assign lanes = {{8{i_wr_strb[3]}}, {8{i_wr_strb[2]}}, {8{i_wr_strb[1]}}, {8{i_wr_strb[0]}}};
	assign bmask = wmask & lanes[31:LSB];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			base_q <= BASE_RESET[31:LSB];
		end else if (i_wr_base) begin
			base_q <= (base_q & ~bmask) | (i_wr_data[31:LSB] & bmask);
		end
	end

	// setup fields move only on the load path
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			atype_q <= ATYPE_RESET;
			pref_q  <= PREF_RESET;
			size_q  <= SIZE_RESET[SIZE_MSB:LSB];
			en_q    <= EN_RESET;
		end else if (i_load) begin
			atype_q <= i_load_data[ATYPE_MSB:ATYPE_LSB];
			pref_q  <= i_load_data[PREF_BIT];
			size_q  <= i_load_data[SIZE_MSB:LSB];
			en_q    <= ALWAYS_ON | i_load_data[EN_BIT];
		end
	end

	assign o_base      = {base_q, {LSB{1'b0}}};
	assign o_setup     = {en_q, size_q, {(LSB-4){1'b0}}, pref_q, atype_q, TYPE_MEMORY};
	assign o_xlat_addr = {(i_addr[31:LSB] & ~wmask) | (base_q & wmask), i_addr[LSB-1:0]};
	assign o_enabled   = en_q;
endmodule
`default_nettype wire

// ===== rtl/upstream_address_translation_windows.sv
// Purpose: AXI4-Lite register bank and address merge for two upstream windows
// Assumes: load path and translate requests come from logic on i_clk
// Notes:   one read may be outstanding at a time; a second write is taken while a response waits
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module upstream_address_translation_windows
	import xlat_win_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire logic        i_setup_load0,
	input  wire logic        i_setup_load1,
	input  wire logic [31:0] i_setup_data,
	input  wire logic        i_xlat_valid,
	input  wire logic [31:0] i_xlat_addr,
	input  wire logic        i_xlat_win1,
	input  wire logic        i_xlat_io,
	output logic             o_xlat_valid,
	output logic [31:0]      o_xlat_addr,
	output logic             o_xlat_hit
);
	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	typedef enum logic [0:0] {
		RD_IDLE,
		RD_RESP
	} rd_state_e;

	rd_state_e   rd_state_q;
	logic        aw_full;
	logic        w_full;
	logic [7:0]  aw_addr;
	logic [35:0] w_payload;
	logic        do_write;
	logic        ar_take;
	logic [7:0]  ra_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] w0_base;
	logic [31:0] w0_setup;
	logic [31:0] w1_base;
	logic [31:0] w1_setup;
	logic [31:0] w0_xlat;
	logic [31:0] w1_xlat;
	logic        w0_en;
	logic        w1_en;
	logic        hit_d;
	logic        xvalid_q;
	logic [31:0] xaddr_q;
	logic        xhit_q;

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFF_W0_BASE) || (a == OFF_W0_SETUP) ||
			(a == OFF_W1_BASE) || (a == OFF_W1_SETUP);
	endfunction

	function automatic logic [31:0] read_mux(input logic [7:0] a,
		input logic [31:0] b0, input logic [31:0] s0,
		input logic [31:0] b1, input logic [31:0] s1);
		case (a)
			OFF_W0_BASE:  read_mux = b0;
			OFF_W0_SETUP: read_mux = s0;
			OFF_W1_BASE:  read_mux = b1;
			OFF_W1_SETUP: read_mux = s1;
			default:      read_mux = 32'h0;
		endcase
	endfunction

	// --------------------------------------------------------------
	// write channels, taken in either order
	// --------------------------------------------------------------
	axil_capture #(.W(8)) u_aw (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_valid   (i_s_axi_awvalid),
		.o_ready   (o_s_axi_awready),
		.i_payload (i_s_axi_awaddr),
		.i_consume (do_write),
		.o_full    (aw_full),
		.o_payload (aw_addr)
	);

	axil_capture #(.W(36)) u_w (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_valid   (i_s_axi_wvalid),
		.o_ready   (o_s_axi_wready),
		.i_payload ({i_s_axi_wstrb, i_s_axi_wdata}),
		.i_consume (do_write),
		.o_full    (w_full),
		.o_payload (w_payload)
	);

	// a pending response holds off the next write
	assign do_write = aw_full & w_full & ~bvalid_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp  = bresp_q;

	// --------------------------------------------------------------
	// windows
	// --------------------------------------------------------------
	xlat_window #(.LSB(W0_LSB), .ALWAYS_ON(1'b1), .EN_RESET(W0_EN_RESET)) u_win0 (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_wr_base   (do_write && aw_addr == OFF_W0_BASE),
		.i_wr_data   (w_payload[31:0]),
		.i_wr_strb   (w_payload[35:32]),
		.i_load      (i_setup_load0),
		.i_load_data (i_setup_data),
		.i_addr      (i_xlat_addr),
		.o_base      (w0_base),
		.o_setup     (w0_setup),
		.o_xlat_addr (w0_xlat),
		.o_enabled   (w0_en)
	);

	xlat_window #(.LSB(W1_LSB), .ALWAYS_ON(1'b0), .EN_RESET(W1_EN_RESET)) u_win1 (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_wr_base   (do_write && aw_addr == OFF_W1_BASE),
		.i_wr_data   (w_payload[31:0]),
		.i_wr_strb   (w_payload[35:32]),
		.i_load      (i_setup_load1),
		.i_load_data (i_setup_data),
		.i_addr      (i_xlat_addr),
		.o_base      (w1_base),
		.o_setup     (w1_setup),
		.o_xlat_addr (w1_xlat),
		.o_enabled   (w1_en)
	);

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	assign ar_take = i_s_axi_arvalid & arready_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_state_q <= RD_IDLE;
			arready_q  <= 1'b0;
		end else begin
			case (rd_state_q)
				RD_IDLE: begin
					arready_q <= ~ar_take;
					if (ar_take) begin
						rd_state_q <= RD_RESP;
					end
				end
				RD_RESP: begin
					if (i_s_axi_rready) begin
						rd_state_q <= RD_IDLE;
						arready_q  <= 1'b1;
					end
				end
				default: begin
					rd_state_q <= RD_IDLE;
					arready_q  <= 1'b0;
				end
			endcase
		end
	end

	// setup words read live from the window, writes to them do nothing
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
			ra_q    <= 8'h0;
		end else if (ar_take) begin
			rdata_q <= read_mux(i_s_axi_araddr, w0_base, w0_setup, w1_base, w1_setup);
			rresp_q <= is_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			ra_q    <= i_s_axi_araddr;
		end
	end

	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid  = (rd_state_q == RD_RESP);
	assign o_s_axi_rdata   = rdata_q;
	assign o_s_axi_rresp   = rresp_q;

	// --------------------------------------------------------------
	// translation stage
	// --------------------------------------------------------------
	// window 0 is memory only, so an i/o request never hits it
	assign hit_d = i_xlat_win1 ? w1_en : (w0_en & ~i_xlat_io);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			xvalid_q <= 1'b0;
			xaddr_q  <= 32'h0;
			xhit_q   <= 1'b0;
		end else begin
			xvalid_q <= i_xlat_valid;
			if (i_xlat_valid) begin
				xhit_q  <= hit_d;
				xaddr_q <= !hit_d ? i_xlat_addr : (i_xlat_win1 ? w1_xlat : w0_xlat);
			end
		end
	end

	assign o_xlat_valid = xvalid_q;
	assign o_xlat_addr  = xaddr_q;
	assign o_xlat_hit   = xhit_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_w0_base_low;
		o_s_axi_rvalid && ra_q == OFF_W0_BASE |-> o_s_axi_rdata[W0_LSB-1:0] == 12'h0;
	endproperty
	a_w0_base_low: assert property (p_w0_base_low) else $error("w0 base low bits set");

	property p_w1_base_low;
		o_s_axi_rvalid && ra_q == OFF_W1_BASE |-> o_s_axi_rdata[W1_LSB-1:0] == 6'h0;
	endproperty
	a_w1_base_low: assert property (p_w1_base_low) else $error("w1 base low bits set");

	property p_type_zero;
		o_s_axi_rvalid && (ra_q == OFF_W0_SETUP || ra_q == OFF_W1_SETUP)
			|-> o_s_axi_rdata[TYPE_BIT] == 1'b0 && o_s_axi_rdata[PREF_BIT+1] == 1'b0;
	endproperty
	a_type_zero: assert property (p_type_zero) else $error("setup type or reserved bit set");

	// the mask in force is the one before any same-cycle load
	property p_masked_write;
		do_write && aw_addr == OFF_W0_BASE && w_payload[35:32] == 4'hf
			|=> w0_base[30:W0_LSB] == (($past(w0_base[30:W0_LSB]) & ~$past(w0_setup[30:W0_LSB]))
				| ($past(w_payload[30:W0_LSB]) & $past(w0_setup[30:W0_LSB])));
	endproperty
	a_masked_write: assert property (p_masked_write) else $error("base ignored size mask");

	property p_w0_always_on;
		i_setup_load0 && !i_setup_data[EN_BIT] |=> w0_en ##1 w0_en;
	endproperty
	a_w0_always_on: assert property (p_w0_always_on) else $error("window 0 turned off");

	property p_w1_off_no_hit;
		i_xlat_valid && i_xlat_win1 && !w1_en |=> o_xlat_valid && !o_xlat_hit
			&& o_xlat_addr == $past(i_xlat_addr);
	endproperty
	a_w1_off_no_hit: assert property (p_w1_off_no_hit) else $error("disabled window 1 hit");

	property p_merge0;
		i_xlat_valid && !i_xlat_win1 && !i_xlat_io |=> o_xlat_hit
			&& o_xlat_addr == {($past(i_xlat_addr[31:W0_LSB]) & ~$past(w0_setup[31:W0_LSB]))
				| ($past(w0_base[31:W0_LSB]) & $past(w0_setup[31:W0_LSB])),
				$past(i_xlat_addr[W0_LSB-1:0])};
	endproperty
	a_merge0: assert property (p_merge0) else $error("window 0 merge wrong");

	property p_setup_write_ignored;
		do_write && (aw_addr == OFF_W0_SETUP || aw_addr == OFF_W1_SETUP)
			&& !i_setup_load0 && !i_setup_load1
			|=> w0_setup == $past(w0_setup) && w1_setup == $past(w1_setup);
	endproperty
	a_setup_write_ignored: assert property (p_setup_write_ignored) else $error("setup took bus write");

	property p_read_answer;
		ar_take |=> o_s_axi_rvalid [*1] ##0 o_s_axi_rresp == (is_mapped($past(i_s_axi_araddr))
			? RESP_OKAY : RESP_SLVERR);
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late or wrong");

	// i/o and memory requests both hit an enabled window 1
	property p_merge1;
		i_xlat_valid && i_xlat_win1 && w1_en |=> o_xlat_hit
			&& o_xlat_addr == {($past(i_xlat_addr[31:W1_LSB]) & ~$past(w1_setup[31:W1_LSB]))
				| ($past(w1_base[31:W1_LSB]) & $past(w1_setup[31:W1_LSB])),
				$past(i_xlat_addr[W1_LSB-1:0])};
	endproperty
	a_merge1: assert property (p_merge1) else $error("window 1 merge wrong");

	property p_io_miss0;
		i_xlat_valid && !i_xlat_win1 && i_xlat_io |=> o_xlat_valid && !o_xlat_hit
			&& o_xlat_addr == $past(i_xlat_addr);
	endproperty
	a_io_miss0: assert property (p_io_miss0) else $error("i/o request hit window 0");

	property p_load_fields0;
		i_setup_load0
			|=> w0_setup[PREF_BIT:ATYPE_LSB] == $past(i_setup_data[PREF_BIT:ATYPE_LSB]);
	endproperty
	a_load_fields0: assert property (p_load_fields0) else $error("fields not loaded");

	property p_w1_en_load;
		i_setup_load1 |=> w1_en == $past(i_setup_data[EN_BIT]);
	endproperty
	a_w1_en_load: assert property (p_w1_en_load) else $error("w1 enable not loaded");

	property p_write_answer;
		do_write |=> o_s_axi_bvalid && o_s_axi_bresp == (is_mapped($past(aw_addr))
			? RESP_OKAY : RESP_SLVERR);
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late or wrong");

	// a stalled response needs a master that holds bready low
	c_write_w1_base: cover property (do_write && aw_addr == OFF_W1_BASE);
	c_w1_hit: cover property (o_xlat_valid && o_xlat_hit && $past(i_xlat_win1));
	c_unmapped_read: cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
	c_bstall: cover property (o_s_axi_bvalid && !i_s_axi_bready ##1 o_s_axi_bvalid);
	c_io_miss0: cover property (i_xlat_valid && !i_xlat_win1 && i_xlat_io);
endmodule
`default_nettype wire

// ===== test/axil_cfg_master.sv
// Purpose: AXI4-Lite master model issuing register writes and reads
// Assumes: slave outputs change only on rising edges of i_clk
// Notes:   waits without limit; the bench timeout ends a hang
`timescale 1ns/1ns
`default_nettype none
module axil_cfg_master (
	input  wire logic        i_clk,
	output var  logic [7:0]  o_awaddr,
	output var  logic        o_awvalid,
	input  wire logic        i_awready,
	output var  logic [31:0] o_wdata,
	output var  logic [3:0]  o_wstrb,
	output var  logic        o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output var  logic        o_bready,
	output var  logic [7:0]  o_araddr,
	output var  logic        o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output var  logic        o_rready
);
	initial begin
		o_awaddr = 8'h00;
		o_awvalid = 1'b0;
		o_wdata = 32'h0;
		o_wstrb = 4'h0;
		o_wvalid = 1'b0;
		o_bready = 1'b0;
		o_araddr = 8'h00;
		o_arvalid = 1'b0;
		o_rready = 1'b0;
	end

	// released payload is inverted so a stale value never looks valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ta;
		logic tw;
		logic tb;
		tb = 1'b0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= s;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (!tb) begin
			@(posedge i_clk);
			ta = o_awvalid && i_awready;
			tw = o_wvalid && i_wready;
			tb = i_bvalid;
			r = i_bresp;
			if (ta) begin
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (tw) begin
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
			if (tb)
				o_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tr;
		tr = 1'b0;
		@(posedge i_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		while (!tr) begin
			@(posedge i_clk);
			ta = o_arvalid && i_arready;
			tr = i_rvalid;
			d = i_rdata;
			r = i_rresp;
			if (ta) begin
				o_arvalid <= 1'b0;
				o_araddr <= ~a;
			end
			if (tr)
				o_rready <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== test/upstream_address_translation_windows_tb.sv
// Purpose: self-checking bench for the translation window registers
// Assumes: 4 ns clock, reset held 20 cycles
// Notes:   expected values come from shadow copies kept here
`timescale 1ns/1ns
`default_nettype none
module upstream_address_translation_windows_tb
	import xlat_win_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        ld0;
	logic        ld1;
	logic [31:0] ld_data;
	logic        xv;
	logic [31:0] xa;
	logic        xw1;
	logic        xio;
	logic        ov;
	logic [31:0] oa;
	logic        oh;
	logic [31:0] s0e;
	logic [31:0] s1e;
	logic [31:0] b0e;
	logic [31:0] b1e;
	int          fails;
	int          total_checks;
	int          cyc = 0;

	upstream_address_translation_windows i_dut (.i_clk(clk), .i_rst_n(rst_n),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_setup_load0(ld0),
		.i_setup_load1(ld1), .i_setup_data(ld_data), .i_xlat_valid(xv), .i_xlat_addr(xa),
		.i_xlat_win1(xw1), .i_xlat_io(xio), .o_xlat_valid(ov), .o_xlat_addr(oa),
		.o_xlat_hit(oh));

	axil_cfg_master u_master (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic wrap_up();
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		u_master.rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic [1:0] r;
		u_master.wr(a, d, s, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	// reserved setup bits read zero, window 0 enable forced on
	task automatic load(input logic w, input logic [31:0] v);
		@(posedge clk);
		ld0 <= !w;
		ld1 <= w;
		ld_data <= v;
		@(posedge clk);
		ld0 <= 1'b0;
		ld1 <= 1'b0;
		ld_data <= ~v;
		if (w)
			s1e = v & 32'hffff_ffce;
		else
			s0e = (v & 32'h7fff_f00e) | 32'h8000_0000;
		rd_chk(w ? OFF_W1_SETUP : OFF_W0_SETUP, w ? s1e : s0e, RESP_OKAY);
	endtask

	task automatic wb(input logic w, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = w ? {1'b1, s1e[30:6], 6'h0} : {1'b1, s0e[30:12], 12'h0};
		m = m & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		wr_chk(w ? OFF_W1_BASE : OFF_W0_BASE, d, s, RESP_OKAY);
		if (w)
			b1e = (b1e & ~m) | (d & m);
		else
			b0e = (b0e & ~m) | (d & m);
		rd_chk(w ? OFF_W1_BASE : OFF_W0_BASE, w ? b1e : b0e, RESP_OKAY);
	endtask

	task automatic xl(input logic [31:0] a, input logic w1, input logic io);
		logic [31:0] m;
		logic [31:0] b;
		logic        h;
		m = w1 ? {1'b1, s1e[30:6], 6'h0} : {1'b1, s0e[30:12], 12'h0};
		b = w1 ? b1e : b0e;
		h = w1 ? s1e[31] : !io;
		@(posedge clk);
		xv <= 1'b1;
		xa <= a;
		xw1 <= w1;
		xio <= io;
		@(posedge clk);
		xv <= 1'b0;
		xa <= ~a;
		@(negedge clk);
		chk("xlat valid", 32'h1, {31'h0, ov});
		chk("xlat hit", {31'h0, h}, {31'h0, oh});
		chk("xlat addr", h ? ((a & ~m) | (b & m)) : a, oa);
		@(negedge clk);
		chk("xlat drop", 32'h0, {31'h0, ov});
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset_values();
		s0e = 32'h8000_0000;
		s1e = 32'h0;
		b0e = 32'h0;
		b1e = 32'h0;
		rd_chk(OFF_W0_BASE, b0e, RESP_OKAY);
		rd_chk(OFF_W0_SETUP, s0e, RESP_OKAY);
		rd_chk(OFF_W1_BASE, b1e, RESP_OKAY);
		rd_chk(OFF_W1_SETUP, s1e, RESP_OKAY);
		rd_chk(8'hf0, 32'h0, RESP_SLVERR);
	endtask

	task automatic t_setup_ro();
		wr_chk(OFF_W0_SETUP, 32'h0, 4'hf, RESP_OKAY);
		wr_chk(OFF_W1_SETUP, 32'hffff_ffff, 4'hf, RESP_OKAY);
		rd_chk(OFF_W0_SETUP, s0e, RESP_OKAY);
		rd_chk(OFF_W1_SETUP, s1e, RESP_OKAY);
	endtask

	task automatic t_loads();
		load(1'b0, 32'h0000_0001);
		load(1'b0, 32'h7fff_f00a);
		load(1'b1, 32'h8000_003f);
		load(1'b1, 32'h0000_0002);
		load(1'b0, 32'h000f_f008);
		load(1'b1, 32'h8fff_f000);
	endtask

	task automatic t_base();
		wb(1'b0, 32'hffff_ffff, 4'hf);
		wb(1'b0, 32'h0, 4'h2);
		wb(1'b1, 32'hffff_ffff, 4'hf);
		wr_chk(8'hf4, 32'h0, 4'hf, RESP_SLVERR);
		rd_chk(OFF_W0_BASE, b0e, RESP_OKAY);
		load(1'b1, 32'hffff_ffc0);
		wb(1'b1, 32'hffff_ffff, 4'hf);
		wb(1'b1, 32'h1234_5680, 4'hf);
	endtask

	task automatic t_xlat();
		xl(32'h1234_5678, 1'b0, 1'b0);
		xl(32'h1234_5678, 1'b0, 1'b1);
		xl(32'h0abc_def1, 1'b1, 1'b1);
		load(1'b1, 32'h0fff_f000);
		xl(32'h0abc_def1, 1'b1, 1'b0);
	endtask

	// mid-run reset returns every register to its start value
	task automatic t_rerst();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_values();
	endtask

	initial begin
		rst_n = 1'b0;
		ld0 = 1'b0;
		ld1 = 1'b0;
		ld_data = 32'h0;
		xv = 1'b0;
		xa = 32'h0;
		xw1 = 1'b0;
		xio = 1'b0;
		fails = 0;
		total_checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset_values();
		t_setup_ro();
		t_loads();
		t_base();
		t_xlat();
		t_rerst();
		wrap_up();
	end
endmodule
`default_nettype wire
